/* logic/sce_defs.svh */
`ifndef SCE_DEFS_SVH
`define SCE_DEFS_SVH
// condition selector codes (5-bit field)
`define SCE_COND_W 5
`define SCE_COND_ALWAYS 5'h00
`define SCE_COND_EQ 5'h01
`define SCE_COND_NE 5'h02
`define SCE_COND_LT 5'h03
`define SCE_COND_GE 5'h04
`define SCE_COND_AC 5'h05
`define SCE_COND_NAC 5'h06
`define SCE_COND_AV 5'h07
`define SCE_COND_NAV 5'h08
`define SCE_COND_MV 5'h09
`define SCE_COND_NMV 5'h0a
`define SCE_COND_SZ 5'h0b
`define SCE_COND_NSZ 5'h0c
`define SCE_COND_TF 5'h0d
`define SCE_COND_NTF 5'h0e
`define SCE_COND_F2T 5'h0f
`define SCE_COND_F2F 5'h10
`define SCE_COND_LCE 5'h11
// status flag bit positions within the arith status word
`define SCE_AZ 0
`define SCE_AN 1
`define SCE_AV 2
`define SCE_AC 3
`define SCE_MV 4
`define SCE_SZ 5
`define SCE_BTF 6
`define SCE_STAT_W 8
`define SCE_STKY_W 8
`define SCE_STK_BITS 3
`define SCE_STAT_RST 8'h00
`endif

/* logic/sce_evaluator.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sce_defs.svh"
// Function
// - dual mode evaluates condition in both elements for instructions and loops
// - each element keeps its own arith and sticky status copies
// - one shared pc, loop address and loop counter stack status
// - stack status bits exist only in primary sticky register
// - dual mode compute runs in each element on its own test
// - conditional jump or call taken on AND of both results
// - indirect branch else part runs per element where its test fails
// - explicit move gated by primary, implicit by secondary, per register types
// - uncomplemented to pair: each element moves independently, same source
// - pair to uncomplemented: explicit move only, primary condition
// - post-modify memory transfer executes on OR of both results
// - pre-modify always happens regardless of conditions
// - loop termination uses AND of both element results
// - dual mode bit test yields separate flag per element
// - broadcast condition uses primary status only
// - select bit: flag2 true runs primary only, false secondary only
// - select bit: flag2 conditions always true for non compute/move
// - single mode tests primary only; that result controls whole operation
module sce_evaluator (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // mode bits
  input wire logic DUAL_PATH_ENABLE,
  input wire logic ELEMENT_SELECT_BIT,
  // instruction request from the sequencer
  input wire sce_pkg::sce_req_t REQ,
  input wire logic FLAG_TWO_INPUT,
  input wire logic LOOP_COUNT_EXPIRED,
  // status updates from each element datapath
  input wire logic PRIM_STAT_WE,
  input wire logic [`SCE_STAT_W-1:0] PRIM_STAT_IN,
  input wire logic SEC_STAT_WE,
  input wire logic [`SCE_STAT_W-1:0] SEC_STAT_IN,
  input wire logic [`SCE_STKY_W-1:0] PRIM_STKY_SET,
  input wire logic [`SCE_STKY_W-1:0] SEC_STKY_SET,
  input wire logic STKY_CLEAR,
  // stack status events from the single shared sequencer stacks
  input wire logic [`SCE_STK_BITS-1:0] STACK_EVENT,
  // bit test results per element
  input wire logic BIT_TEST_WE,
  input wire logic PRIM_BIT_TEST,
  input wire logic SEC_BIT_TEST,
  // gating outputs
  output sce_pkg::sce_gate_t GATE,
  // status visible to software
  output logic [`SCE_STAT_W-1:0] PRIMARY_ARITH_STATUS,
  output logic [`SCE_STAT_W-1:0] SECONDARY_ARITH_STATUS,
  output logic [`SCE_STKY_W+`SCE_STK_BITS-1:0] PRIMARY_STICKY_STATUS,
  output logic [`SCE_STKY_W-1:0] SECONDARY_STICKY_STATUS
);
  // ----------------------------------------------------------------
  // status registers
  // ----------------------------------------------------------------
  logic [`SCE_STAT_W-1:0] pstat_q, sstat_q, pstat_d, sstat_d;
  logic [`SCE_STKY_W-1:0] pstky_q, sstky_q;
  logic [`SCE_STK_BITS-1:0] stk_q;
  sce_pkg::sce_gate_t gate_d, gate_q;

  // bit test writes override the btf bit of each copy separately
  always_comb begin
    pstat_d = PRIM_STAT_WE ? PRIM_STAT_IN : pstat_q;
    sstat_d = SEC_STAT_WE ? SEC_STAT_IN : sstat_q;
    if (BIT_TEST_WE) begin
      pstat_d[`SCE_BTF] = PRIM_BIT_TEST;
      sstat_d[`SCE_BTF] = SEC_BIT_TEST;
    end
  end

  // sticky bits: a set in the clearing cycle wins
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      pstat_q <= `SCE_STAT_RST;
      sstat_q <= `SCE_STAT_RST;
      pstky_q <= '0;
      sstky_q <= '0;
      stk_q <= '0;
    end else begin
      pstat_q <= pstat_d;
      sstat_q <= sstat_d;
      pstky_q <= (STKY_CLEAR ? '0 : pstky_q) | PRIM_STKY_SET;
      sstky_q <= (STKY_CLEAR ? '0 : sstky_q) | SEC_STKY_SET;
      stk_q <= (STKY_CLEAR ? '0 : stk_q) | STACK_EVENT;
    end
  end

  assign PRIMARY_ARITH_STATUS = pstat_q;
  assign SECONDARY_ARITH_STATUS = sstat_q;
  // stack bits appended only to the primary sticky copy
  assign PRIMARY_STICKY_STATUS = {stk_q, pstky_q};
  assign SECONDARY_STICKY_STATUS = sstky_q;

  // ----------------------------------------------------------------
  // condition evaluation per element
  // ----------------------------------------------------------------
  function automatic logic cond_eval(input logic [4:0] c,
                                     input logic [`SCE_STAT_W-1:0] s,
                                     input logic lce);
    logic r;
    r = 1'b1;
    unique case (c)
      `SCE_COND_EQ: r = s[`SCE_AZ];
      `SCE_COND_NE: r = !s[`SCE_AZ];
      `SCE_COND_LT: r = s[`SCE_AN] && !s[`SCE_AZ];
      `SCE_COND_GE: r = !s[`SCE_AN] || s[`SCE_AZ];
      `SCE_COND_AC: r = s[`SCE_AC];
      `SCE_COND_NAC: r = !s[`SCE_AC];
      `SCE_COND_AV: r = s[`SCE_AV];
      `SCE_COND_NAV: r = !s[`SCE_AV];
      `SCE_COND_MV: r = s[`SCE_MV];
      `SCE_COND_NMV: r = !s[`SCE_MV];
      `SCE_COND_SZ: r = s[`SCE_SZ];
      `SCE_COND_NSZ: r = !s[`SCE_SZ];
      `SCE_COND_TF: r = s[`SCE_BTF];
      `SCE_COND_NTF: r = !s[`SCE_BTF];
      `SCE_COND_LCE: r = lce;
      default: r = 1'b1; // always, and flag2 handled outside
    endcase
    return r;
  endfunction : cond_eval

  wire is_f2t = (REQ.cond == `SCE_COND_F2T);
  wire is_f2f = (REQ.cond == `SCE_COND_F2F);
  wire is_f2 = is_f2t || is_f2f;
  wire f2_level = is_f2t ? FLAG_TWO_INPUT : !FLAG_TWO_INPUT;
  wire cm_op = (REQ.op == sce_pkg::OP_COMPUTE) ||
               (REQ.op == sce_pkg::OP_MOVE);
  // raw results; secondary only matters in dual mode
  wire px_raw = is_f2 ? f2_level
                      : cond_eval(REQ.cond, pstat_q, LOOP_COUNT_EXPIRED);
  wire py_raw = is_f2 ? f2_level
                      : cond_eval(REQ.cond, sstat_q, LOOP_COUNT_EXPIRED);
  // element select steers flag2 conditions to one element
  wire sel_f2 = ELEMENT_SELECT_BIT && is_f2;
  wire px_c = sel_f2 ? (cm_op ? is_f2t : 1'b1) : px_raw;
  wire py_c = sel_f2 ? (cm_op ? is_f2f : 1'b1) : py_raw;
  // single mode ignores secondary; it then simply follows the primary
  wire py_eff = DUAL_PATH_ENABLE ? py_c : px_c;
  wire both = px_c && py_eff;
  wire either = px_c || py_eff;
  wire v = REQ.valid;
  wire dual = DUAL_PATH_ENABLE;

  // ----------------------------------------------------------------
  // gate generation
  // ----------------------------------------------------------------
  always_comb begin
    gate_d = '0;
    if (v) begin
      unique case (REQ.op)
        sce_pkg::OP_COMPUTE: begin
          gate_d.prim_exec = px_c;
          gate_d.sec_exec = dual && py_c;
        end
        sce_pkg::OP_MOVE: begin
          gate_d.explicit_mv = px_c;
          // pair targets get the implicit half; uncomplemented ones do not
          gate_d.implicit_mv = dual && py_c &&
            (REQ.mv == sce_pkg::MV_PAIR_PAIR ||
             REQ.mv == sce_pkg::MV_UNC_PAIR);
        end
        sce_pkg::OP_MEM_POST: begin
          gate_d.mem_exec = dual ? either : px_c;
          gate_d.explicit_mv = px_c;
          gate_d.implicit_mv = dual && py_c;
        end
        sce_pkg::OP_MEM_PRE: begin
          gate_d.premod = 1'b1;
          gate_d.mem_exec = dual ? either : px_c;
          gate_d.explicit_mv = px_c;
          gate_d.implicit_mv = dual && py_c;
        end
        sce_pkg::OP_BRANCH: begin
          gate_d.seq_take = both;
          if (REQ.has_else) begin
            gate_d.prim_else = !px_c;
            gate_d.sec_else = dual && !py_c;
          end
        end
        sce_pkg::OP_IDX_ELSE: begin
          gate_d.seq_take = both;
          gate_d.prim_else = !px_c;
          gate_d.sec_else = dual && !py_c;
        end
        sce_pkg::OP_LOOP: gate_d.seq_take = both;
        sce_pkg::OP_BROADCAST: begin
          gate_d.prim_exec = px_c;
          gate_d.sec_exec = dual && px_c;
        end
      endcase
    end
  end

  // gates registered so data outputs come from flip-flops
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      gate_q <= '0;
    end else begin
      gate_q <= gate_d;
    end
  end
  assign GATE = gate_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  a_branch_and_gate: assert property (
    v && REQ.op == sce_pkg::OP_BRANCH |=> GATE.seq_take == $past(both))
    else $error("branch take mismatch");
  a_loop_and_gate: assert property (
    v && REQ.op == sce_pkg::OP_LOOP && !px_c |=> !GATE.seq_take)
    else $error("loop ended though primary false");
  a_post_or_gate: assert property (
    v && REQ.op == sce_pkg::OP_MEM_POST && dual && (px_c || py_c)
    |=> GATE.mem_exec)
    else $error("post-modify transfer missed");
  a_premod_always: assert property (
    v && REQ.op == sce_pkg::OP_MEM_PRE |=> GATE.premod)
    else $error("pre-modify dropped");
  a_single_no_sec: assert property (
    !dual |=> !GATE.sec_exec || $past(REQ.op) == sce_pkg::OP_BROADCAST)
    else $error("secondary ran in single mode");
  a_sel_f2_prim: assert property (
    v && ELEMENT_SELECT_BIT && is_f2t && REQ.op == sce_pkg::OP_COMPUTE
    |=> GATE.prim_exec && !GATE.sec_exec)
    else $error("flag2 true select wrong");
  a_sel_f2_jump: assert property (
    v && ELEMENT_SELECT_BIT && is_f2 && REQ.op == sce_pkg::OP_BRANCH
    |=> GATE.seq_take)
    else $error("flag2 jump not forced");
  a_unc_no_implicit: assert property (
    v && REQ.op == sce_pkg::OP_MOVE && REQ.mv == sce_pkg::MV_PAIR_UNC
    |=> !GATE.implicit_mv)
    else $error("implicit move to uncomplemented reg");
  a_bcast_primary: assert property (
    v && dual && REQ.op == sce_pkg::OP_BROADCAST
    |=> GATE.sec_exec == GATE.prim_exec)
    else $error("broadcast used secondary status");
  a_sticky_hold: assert property (
    |PRIM_STKY_SET
    |=> (pstky_q & $past(PRIM_STKY_SET)) == $past(PRIM_STKY_SET))
    else $error("sticky set lost");
  // further checks: per element gating, select bit, bit test flags, sticky and stack status
  a_sel_f2_sec: assert property (
    v && ELEMENT_SELECT_BIT && is_f2f && REQ.op == sce_pkg::OP_COMPUTE
    |=> !GATE.prim_exec && GATE.sec_exec == $past(dual))
    else $error("flag2 false select wrong");
  a_compute_split: assert property (
    v && REQ.op == sce_pkg::OP_COMPUTE && !ELEMENT_SELECT_BIT && dual
    |=> GATE.prim_exec == $past(px_raw) && GATE.sec_exec == $past(py_raw))
    else $error("compute gating not per element");
  a_single_prim_only: assert property (
    v && !dual && !ELEMENT_SELECT_BIT && REQ.op == sce_pkg::OP_BRANCH
    |=> GATE.seq_take == $past(px_raw))
    else $error("single mode used secondary");
  a_move_explicit: assert property (
    v && REQ.op == sce_pkg::OP_MOVE |=> GATE.explicit_mv == $past(px_c))
    else $error("explicit move not primary gated");
  a_unc_pair_implicit: assert property (
    v && dual && REQ.op == sce_pkg::OP_MOVE && REQ.mv == sce_pkg::MV_UNC_PAIR
    |=> GATE.implicit_mv == $past(py_c))
    else $error("implicit move to pair not secondary gated");
  a_idx_else_split: assert property (
    v && dual && REQ.op == sce_pkg::OP_IDX_ELSE
    |=> GATE.prim_else == !$past(px_c) && GATE.sec_else == !$past(py_c))
    else $error("else part not per element");
  a_dual_both_eval: assert property (
    v && dual && REQ.op == sce_pkg::OP_LOOP
    |=> GATE.seq_take == $past(px_c && py_c))
    else $error("loop test ignored an element");
  a_btf_split: assert property (
    BIT_TEST_WE |=> PRIMARY_ARITH_STATUS[`SCE_BTF] == $past(PRIM_BIT_TEST)
    && SECONDARY_ARITH_STATUS[`SCE_BTF] == $past(SEC_BIT_TEST))
    else $error("bit test flags not separate");
  a_sec_sticky_apart: assert property (
    !(|SEC_STKY_SET) && !STKY_CLEAR |=> $stable(SECONDARY_STICKY_STATUS))
    else $error("secondary sticky moved without a set");
  a_stack_shared: assert property (
    |STACK_EVENT |=> (PRIMARY_STICKY_STATUS[`SCE_STKY_W +: `SCE_STK_BITS]
    & $past(STACK_EVENT)) == $past(STACK_EVENT))
    else $error("stack status event lost");
  a_bcast_single: assert property (
    v && !dual && REQ.op == sce_pkg::OP_BROADCAST
    |=> GATE.prim_exec == $past(px_c) && !GATE.sec_exec)
    else $error("broadcast gating wrong in single mode");

  c_dual_split: cover property (v && dual && REQ.op == sce_pkg::OP_COMPUTE
    && px_c != py_c);
  c_branch_taken: cover property (GATE.seq_take);
  c_else_sec: cover property (GATE.sec_else);
  c_sel_f2f: cover property (v && ELEMENT_SELECT_BIT && is_f2f && cm_op);
  c_post_or: cover property (GATE.mem_exec && !GATE.explicit_mv);
endmodule : sce_evaluator
`default_nettype wire

/* logic/sce_pkg.sv */
package sce_pkg;
  // kind of conditional instruction presented by the sequencer
  typedef enum logic [2:0] {
    OP_COMPUTE, OP_MOVE, OP_MEM_POST, OP_MEM_PRE,
    OP_BRANCH, OP_LOOP, OP_BROADCAST, OP_IDX_ELSE
  } sce_op_t;
  // register class of a data move
  typedef enum logic [1:0] {
    MV_PAIR_PAIR, MV_UNC_PAIR, MV_PAIR_UNC, MV_UNC_UNC
  } sce_mv_t;
  typedef struct packed {
    logic valid;
    sce_op_t op;
    sce_mv_t mv;
    logic [4:0] cond;
    logic has_else;
  } sce_req_t;
  typedef struct packed {
    logic prim_exec;
    logic sec_exec;
    logic prim_else;
    logic sec_else;
    logic explicit_mv;
    logic implicit_mv;
    logic mem_exec;
    logic premod;
    logic seq_take;
  } sce_gate_t;
endpackage : sce_pkg

/* tb/sce_evaluator_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sce_defs.svh"
module sce_evaluator_bench;
  // --------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------
  logic clock = 1'b0, reset = 1'b1, dual = 1'b0, sel = 1'b0;
  logic f2 = 1'b0, lce = 1'b0, bt = 1'b0, clr = 1'b0, pend = 1'b0;
  sce_pkg::sce_req_t req = '0;
  logic [1:0] we = 2'h0, bits = 2'h0;
  logic [15:0] val = 16'h0000;
  logic [7:0] pset = 8'h00, sset = 8'h00, mp = 8'h00, ms = 8'h00;
  logic [2:0] stk = 3'h0;
  wire logic p_we, s_we, b_we, p_bt, s_bt;
  wire logic [7:0] p_val, s_val;
  sce_pkg::sce_gate_t gate;
  logic [7:0] pst, sst, sstk;
  logic [10:0] pstk;
  logic [17:0] notes[$];
  logic [17:0] note;
  int num_errors = 0, cmp_count = 0, seed = 20;
  // fields that each kind of request drives; all others must stay low
  localparam logic [8:0] OPMASK [8] = '{9'h180, 9'h018, 9'h01c,
    9'h01e, 9'h061, 9'h001, 9'h180, 9'h061};
  localparam logic [4:0] CODES [18] = '{5'h00, 5'h01, 5'h02, 5'h03,
    5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c,
    5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11};

  always #2 clock = ~clock;

  sce_far_side far (.cmd_we(we), .cmd_val(val), .cmd_bt(bt),
    .cmd_bits(bits), .prim_we(p_we), .prim_val(p_val), .sec_we(s_we),
    .sec_val(s_val), .bt_we(b_we), .prim_bt(p_bt), .sec_bt(s_bt));
  sce_evaluator dut (.CLOCK(clock), .RESET(reset),
    .DUAL_PATH_ENABLE(dual), .ELEMENT_SELECT_BIT(sel), .REQ(req),
    .FLAG_TWO_INPUT(f2), .LOOP_COUNT_EXPIRED(lce), .PRIM_STAT_WE(p_we),
    .PRIM_STAT_IN(p_val), .SEC_STAT_WE(s_we), .SEC_STAT_IN(s_val),
    .PRIM_STKY_SET(pset), .SEC_STKY_SET(sset), .STKY_CLEAR(clr),
    .STACK_EVENT(stk), .BIT_TEST_WE(b_we), .PRIM_BIT_TEST(p_bt),
    .SEC_BIT_TEST(s_bt), .GATE(gate), .PRIMARY_ARITH_STATUS(pst),
    .SECONDARY_ARITH_STATUS(sst), .PRIMARY_STICKY_STATUS(pstk),
    .SECONDARY_STICKY_STATUS(sstk));

  // --------------------------------------------------
  // compares and expectations
  // --------------------------------------------------
  task automatic cmp_gate(logic [8:0] got, logic [8:0] e, logic [8:0] m);
    cmp_count++;
    // a stray pulse on an unused field counts as well
    if (got !== (e & m)) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, e & m);
    end
  endtask : cmp_gate

  task automatic cmp_stat(logic [15:0] got, logic [15:0] e);
    cmp_count++;
    if (got !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, e);
    end
  endtask : cmp_stat

  // odd codes test a flag, the even partner its complement
  function automatic logic cond_ok(logic [4:0] c, logic [7:0] s);
    logic n;
    n = !c[0];
    case (c)
      5'h01, 5'h02: return s[`SCE_AZ] ^ n;
      5'h03: return s[`SCE_AN] && !s[`SCE_AZ];
      5'h04: return !s[`SCE_AN] || s[`SCE_AZ];
      5'h05, 5'h06: return s[`SCE_AC] ^ n;
      5'h07, 5'h08: return s[`SCE_AV] ^ n;
      5'h09, 5'h0a: return s[`SCE_MV] ^ n;
      5'h0b, 5'h0c: return s[`SCE_SZ] ^ n;
      5'h0d, 5'h0e: return s[`SCE_BTF] ^ n;
      5'h0f, 5'h10: return f2 ^ n;
      5'h11: return lce;
      default: return 1'b1;
    endcase
  endfunction : cond_ok

  // status loads land at the edge, so mirrors follow after it
  task automatic tick;
    @(negedge clock);
    if (we[1]) mp = val[15:8];
    if (we[0]) ms = val[7:0];
    if (bt) begin
      mp[`SCE_BTF] = bits[1];
      ms[`SCE_BTF] = bits[0];
    end
  endtask : tick

  task automatic issue(sce_pkg::sce_op_t op, sce_pkg::sce_mv_t mv,
                       logic [4:0] c, logic he);
    logic px, py, cm, el;
    sce_pkg::sce_gate_t e;
    cm = op inside {sce_pkg::OP_COMPUTE, sce_pkg::OP_MOVE};
    px = cond_ok(c, mp);
    py = cond_ok(c, ms);
    if (sel && c inside {5'h0f, 5'h10}) begin
      px = !cm || c == 5'h0f;
      py = !cm || c == 5'h10;
    end
    py = py && dual;
    el = he || op == sce_pkg::OP_IDX_ELSE;
    e.prim_exec = px;
    e.sec_exec = op == sce_pkg::OP_BROADCAST ? dual && px : py;
    e.prim_else = el && !px;
    e.sec_else = el && dual && !py;
    e.explicit_mv = px;
    // memory transfers gate the implicit half whatever the register class
    e.implicit_mv = py && (op != sce_pkg::OP_MOVE ||
                           mv <= sce_pkg::MV_UNC_PAIR);
    e.mem_exec = px || py;
    e.premod = 1'b1;
    e.seq_take = px && (py || !dual);
    req = {1'b1, op, mv, c, he};
    notes.push_back({e, OPMASK[op]});
    tick();
  endtask : issue

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // --------------------------------------------------
  // result watcher: one gate pulse per request, a cycle later
  // --------------------------------------------------
  always @(posedge clock) pend <= req.valid && !reset;
  always @(negedge clock) begin
    if (pend) begin
      note = notes.pop_front();
      cmp_gate(gate, note[17:9], note[8:0]);
    end else if (!reset)
      cmp_gate(gate, 9'h000, 9'h1ff);
  end

  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    repeat (2) @(negedge clock);
    reset = 1'b0;
    cmp_stat({3'h0, pst | sst | sstk} | pstk, 11'h000);
    $display("test reset done");
    // random traffic with loads in the same cycle as requests
    for (int i = 0; i < 400; i++) begin
      dual = 1'($random(seed));
      f2 = 1'($random(seed));
      lce = 1'($random(seed));
      we = 2'($random(seed));
      val = 16'($random(seed));
      if (($random(seed) & 3) == 0) begin
        req = '0;
        tick();
      end else
        issue(sce_pkg::sce_op_t'(3'($random(seed))),
              sce_pkg::sce_mv_t'(2'($random(seed))),
              CODES[$unsigned($random(seed)) % 18], 1'($random(seed)));
      cmp_stat({pst, sst}, {mp, ms});
    end
    we = 2'h0;
    $display("test random done");
    // select bit on every op class except the two memory transfers
    sel = 1'b1;
    for (int i = 0; i < 16; i++) begin
      dual = i[3];
      f2 = 1'($random(seed));
      // jumps and loops probe the forced-true case on purpose
      if (i[2:1] != 2'h1)
        issue(sce_pkg::sce_op_t'({i[2:1], 1'b0}),
              sce_pkg::MV_PAIR_PAIR, i[0] ? 5'h10 : 5'h0f, 1'b0);
      issue(sce_pkg::sce_op_t'(i[2:1] == 2'h1 ? 3'h1 : {i[2:1], 1'b1}),
            sce_pkg::MV_UNC_PAIR, i[0] ? 5'h10 : 5'h0f, 1'b0);
    end
    sel = 1'b0;
    req = '0;
    $display("test select done");
    // separate bit test flags feed one branch and one compute
    dual = 1'b1;
    bt = 1'b1;
    bits = 2'h2;
    tick();
    bt = 1'b0;
    cmp_stat({pst[`SCE_BTF], sst[`SCE_BTF]}, 11'h002);
    issue(sce_pkg::OP_COMPUTE, sce_pkg::MV_PAIR_PAIR, 5'h0d, 1'b0);
    issue(sce_pkg::OP_BRANCH, sce_pkg::MV_PAIR_PAIR, 5'h0d, 1'b1);
    req = '0;
    $display("test bit test done");
    // stickies per element, stack bits in the primary copy only
    pset = 8'ha5;
    sset = 8'h3c;
    stk = 3'h5;
    tick();
    pset = 8'h00;
    sset = 8'h00;
    stk = 3'h0;
    tick();
    cmp_stat(pstk, {3'h5, 8'ha5});
    cmp_stat({3'h0, sstk}, 11'h03c);
    clr = 1'b1;
    tick();
    clr = 1'b0;
    tick();
    cmp_stat(pstk | {3'h0, sstk}, 11'h000);
    // a set landing in the clearing cycle must survive the clear
    pset = 8'h0f;
    tick();
    clr = 1'b1;
    pset = 8'h80;
    stk = 3'h2;
    tick();
    clr = 1'b0;
    pset = 8'h00;
    stk = 3'h0;
    tick();
    cmp_stat(pstk, {3'h2, 8'h80});
    $display("test sticky done");
    for (int k = 0; k < 4 && notes.size() > 0; k++) tick();
    if (notes.size() > 0) num_errors++;
    summarize();
  end
endmodule : sce_evaluator_bench
`default_nettype wire

/* tb/sce_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------
// datapath side model: status words and bit tests
// --------------------------------------------------
module sce_far_side (
  // commands from the bench
  input wire logic [1:0] cmd_we,
  input wire logic [15:0] cmd_val,
  input wire logic cmd_bt,
  input wire logic [1:0] cmd_bits,
  // status traffic toward the evaluator
  output logic prim_we,
  output logic [7:0] prim_val,
  output logic sec_we,
  output logic [7:0] sec_val,
  output logic bt_we,
  output logic prim_bt,
  output logic sec_bt
);
  // each element writes only its own status copy
  assign prim_we = cmd_we[1];
  assign sec_we = cmd_we[0];
  // an idle status bus shows junk, so a stray load is caught
  assign prim_val = cmd_we[1] ? cmd_val[15:8] : ~cmd_val[15:8];
  assign sec_val = cmd_we[0] ? cmd_val[7:0] : ~cmd_val[7:0];
  // one bit test result per register of the pair; a plain bit test is
  // the only shifter traffic, no bit fifo operation is ever modelled
  assign bt_we = cmd_bt;
  assign prim_bt = cmd_bits[1];
  assign sec_bt = cmd_bits[0];
endmodule : sce_far_side
`default_nettype wire
